//--- sdram_aux_pkg.sv
// package: register map, field layout, event codes and carriers of the sdram auxiliary block
`default_nettype none
package sdram_aux_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int REG_AW = 8;
	localparam logic [REG_AW-1:0] OFF_POWER_MGMT_CONTROL = 8'h38;
	localparam logic [REG_AW-1:0] OFF_EVENT_COUNTER_ONE = 8'h80;
	localparam logic [REG_AW-1:0] OFF_EVENT_COUNTER_TWO = 8'h84;
	localparam logic [REG_AW-1:0] OFF_EVENT_COUNTER_SETUP = 8'h88;
	localparam logic [REG_AW-1:0] OFF_FILTER_VALUE_SELECT = 8'h8c;
	localparam logic [REG_AW-1:0] OFF_SCRAMBLE_CONTROL = 8'hc0;
	localparam logic [REG_AW-1:0] OFF_SCRAMBLE_KEY = 8'hc4;
	localparam logic [REG_AW-1:0] OFF_AUX_STATUS = 8'hc8;

	// ****************************************
	// field layout
	// ****************************************
	localparam int IDLE_LSB = 0;
	localparam int IDLE_W = 8;
	localparam int LPSEL_LSB = 8;
	localparam int LPSEL_W = 3;
	localparam logic [LPSEL_W-1:0] LPSEL_AUTO_PD = 3'h4;
	// setup and select registers hold one 16-bit half per counter
	localparam int CNT_HALF = 16;
	localparam int CODE_LSB = 0;
	localparam int CODE_W = 4;
	localparam int REGION_ON_BIT = 14;
	localparam int INITIATOR_ON_BIT = 15;
	localparam int SEL_REGION_LSB = 0;
	localparam int SEL_MASTER_LSB = 8;
	localparam int MASTER_W = 8;
	localparam int REGION_W = 2;
	localparam int SCR_ENABLE_BIT = 0;
	localparam int KEY_W = 16;
	localparam int ST_POWER_DOWN_BIT = 0;
	localparam int ST_SCR_ACTIVE_BIT = 1;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

	// ****************************************
	// event codes
	// ****************************************
	localparam logic [CODE_W-1:0] EV_ACCESS = 4'h0;
	localparam logic [CODE_W-1:0] EV_ACTIVATE = 4'h1;
	localparam logic [CODE_W-1:0] EV_READ = 4'h2;
	localparam logic [CODE_W-1:0] EV_WRITE = 4'h3;
	localparam logic [CODE_W-1:0] EV_CMDQ_FULL = 4'h4;
	localparam logic [CODE_W-1:0] EV_WDATQ_FULL = 4'h5;
	localparam logic [CODE_W-1:0] EV_RDATQ_FULL = 4'h6;
	localparam logic [CODE_W-1:0] EV_WSTATQ_FULL = 4'h7;
	localparam logic [CODE_W-1:0] EV_ELEVATE = 4'h8;
	localparam logic [CODE_W-1:0] EV_PENDING = 4'h9;
	localparam logic [CODE_W-1:0] EV_XFER = 4'ha;
	localparam logic [CODE_W-1:0] EV_MERGE_RD = 4'hb;
	localparam logic [CODE_W-1:0] EV_MERGE_WR = 4'hc;

	// ****************************************
	// scrambler constants
	// ****************************************
	localparam int DATA_W = 64;
	localparam int ADDR_W = 32;
	localparam int PAGE_LSB = 10;
	localparam logic [KEY_W-1:0] KEY_SALT = 16'ha5a5;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic valid;
		logic activate;
		logic is_read;
		logic is_write;
		logic elevate;
		logic merge_rd;
		logic merge_wr;
		logic [MASTER_W-1:0] master_id;
		logic [REGION_W-1:0] region;
	} cmd_ev_s;

	typedef struct packed {
		logic cmd_full;
		logic wdat_full;
		logic rdat_full;
		logic wstat_full;
		logic cmd_pending;
		logic xfer_busy;
	} q_stat_s;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mem_beat_s;

	typedef enum logic {PD_AWAKE, PD_ASLEEP} pd_state_e;

endpackage
`default_nettype wire

//--- sdram_aux.sv
// sdram controller auxiliaries: data scrambler, automatic power-down, two event counters
//
// What this block does
// - only sdram data beats are scrambled; register writes never pass the scrambler
// - enabling scrambling captures the software key; the captured copy is used afterwards
// - captured key expands to 64 bits; scrambles writes and unscrambles reads
// - each word xored with derived key and four rotated 16-bit page address copies
// - scrambling adds no cycles; both settings use the same single register stage
// - power select 4 enters power-down after the programmed count of idle cycles
// - in power-down the memory clock keeps toggling and clock enable stays low
// - register reads and writes keep working during power-down
// - leave power-down on select change, memory request or urgent refresh
// - two independent 32-bit event counters, each with its own event code
// - command events count when the command is accepted into the queue
// - codes 0 to 3 count accesses, activates, reads, writes; 8 priority elevations
// - codes 4 to 7 count half-rate cycles with each queue full
// - code 9 counts pending half-rate cycles, code a transfer half-rate cycles
// - codes b and c count merge read and write bursts; d to f count nothing
// - each counter has its own initiator and region filter enables, off at reset
// - initiator filter acts on codes 0-3, 8, c; region filter on 2, 3, 8
// - filter values come from the separate filter value select register
//
// The register addresses and the plain strobed port are this design's own decisions.
`default_nettype none
module sdram_aux
	import sdram_aux_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// register port
	input wire logic [REG_AW-1:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	// write data towards the sdram
	input wire mem_beat_s WR_BEAT_I,
	output mem_beat_s WR_BEAT_O,
	// read data back from the sdram
	input wire mem_beat_s RD_BEAT_I,
	output mem_beat_s RD_BEAT_O,
	// scheduler activity and queue state
	input wire cmd_ev_s CMD_EV_I,
	input wire q_stat_s Q_STAT_I,
	input wire logic MEM_REQ_I,
	input wire logic REFRESH_URGENT_I,
	// memory clock pins
	output logic MEM_CLK_O,
	output logic MEM_CLOCK_ENABLE_OUT_O,
	output logic POWER_DOWN_O
);

	// ****************************************
	// register file
	// ****************************************
	logic [LPSEL_W-1:0] low_power_select_q;
	logic [IDLE_W-1:0] idle_to_sleep_cycles_q;
	logic [31:0] event_counter_setup_q;
	logic [31:0] filter_value_select_q;
	logic scr_enable_q;
	logic [KEY_W-1:0] key_q;
	logic [KEY_W-1:0] key_lat_q;
	logic [31:0] count_q [2];
	pd_state_e pd_state_q;
	logic wr_ctl;

	assign wr_ctl = REG_WR_I && (REG_ADDR_I == OFF_SCRAMBLE_CONTROL);

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			low_power_select_q <= '0;
			idle_to_sleep_cycles_q <= '0;
			event_counter_setup_q <= RESET_ZERO;
			filter_value_select_q <= RESET_ZERO;
			key_q <= '0;
		end else if (REG_WR_I) begin
			case (REG_ADDR_I)
				OFF_POWER_MGMT_CONTROL: begin
					low_power_select_q <= REG_WDATA_I[LPSEL_LSB +: LPSEL_W];
					idle_to_sleep_cycles_q <= REG_WDATA_I[IDLE_LSB +: IDLE_W];
				end
				OFF_EVENT_COUNTER_SETUP: event_counter_setup_q <= REG_WDATA_I;
				OFF_FILTER_VALUE_SELECT: filter_value_select_q <= REG_WDATA_I;
				OFF_SCRAMBLE_KEY: key_q <= REG_WDATA_I[KEY_W-1:0];
				default: ;
			endcase
		end
	end

	// the key is latched on the rising edge of the enable only; later key writes are
	// harmless to the live scrambler and to reads of data already stored until the next enable
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			scr_enable_q <= 1'b0;
			key_lat_q <= '0;
		end else if (wr_ctl) begin
			scr_enable_q <= REG_WDATA_I[SCR_ENABLE_BIT];
			if (REG_WDATA_I[SCR_ENABLE_BIT] && !scr_enable_q) begin
				key_lat_q <= key_q;
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			REG_RDATA_O <= '0;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				OFF_POWER_MGMT_CONTROL: REG_RDATA_O <= {21'h000000, low_power_select_q, idle_to_sleep_cycles_q};
				OFF_EVENT_COUNTER_ONE: REG_RDATA_O <= count_q[0];
				OFF_EVENT_COUNTER_TWO: REG_RDATA_O <= count_q[1];
				OFF_EVENT_COUNTER_SETUP: REG_RDATA_O <= event_counter_setup_q;
				OFF_FILTER_VALUE_SELECT: REG_RDATA_O <= filter_value_select_q;
				OFF_SCRAMBLE_CONTROL: REG_RDATA_O <= {31'h00000000, scr_enable_q};
				OFF_SCRAMBLE_KEY: REG_RDATA_O <= {16'h0000, key_q};
				OFF_AUX_STATUS: REG_RDATA_O <= {30'h00000000, scr_enable_q, pd_state_q == PD_ASLEEP};
				default: REG_RDATA_O <= '0;
			endcase
		end else begin
			REG_RDATA_O <= '0;
		end
	end

	// ****************************************
	// data scrambler
	// ****************************************
	logic [DATA_W-1:0] key_wide;

	// derived key: four differently mixed copies of the captured key
	assign key_wide = {key_lat_q, ~key_lat_q, {key_lat_q[10:0], key_lat_q[15:11]},
		key_lat_q ^ KEY_SALT};

	function automatic logic [DATA_W-1:0] page_mask(input logic [ADDR_W-1:0] a);
		logic [KEY_W-1:0] page;
		page = a[PAGE_LSB +: KEY_W];
		return {4{page[14:0], page[15]}};
	endfunction

	// the xor sits in the same register stage that exists with scrambling off
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			WR_BEAT_O <= '0;
			RD_BEAT_O <= '0;
		end else begin
			WR_BEAT_O <= WR_BEAT_I;
			RD_BEAT_O <= RD_BEAT_I;
			if (scr_enable_q) begin
				WR_BEAT_O.data <= WR_BEAT_I.data ^ key_wide ^ page_mask(WR_BEAT_I.addr);
				RD_BEAT_O.data <= RD_BEAT_I.data ^ key_wide ^ page_mask(RD_BEAT_I.addr);
			end
		end
	end

	// ****************************************
	// automatic power-down
	// ****************************************
	logic [IDLE_W-1:0] idle_cnt_q;
	logic busy;
	logic wake;

	assign busy = CMD_EV_I.valid || MEM_REQ_I || Q_STAT_I.cmd_pending || Q_STAT_I.xfer_busy;
	assign wake = (low_power_select_q != LPSEL_AUTO_PD) || MEM_REQ_I || REFRESH_URGENT_I;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			idle_cnt_q <= '0;
		end else if (busy || pd_state_q == PD_ASLEEP) begin
			idle_cnt_q <= '0;
		end else if (idle_cnt_q != idle_to_sleep_cycles_q) begin
			idle_cnt_q <= idle_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pd_state_q <= PD_AWAKE;
		end else begin
			case (pd_state_q)
				PD_AWAKE: begin
					if (!wake && !busy && idle_cnt_q == idle_to_sleep_cycles_q) begin
						pd_state_q <= PD_ASLEEP;
					end
				end
				PD_ASLEEP: begin
					if (wake) begin
						pd_state_q <= PD_AWAKE;
					end
				end
				default: pd_state_q <= PD_AWAKE;
			endcase
		end
	end

	// memory clock runs free in every state; only the enable and POWER_DOWN_O follow power-down
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			MEM_CLK_O <= 1'b0;
			MEM_CLOCK_ENABLE_OUT_O <= 1'b0;
			POWER_DOWN_O <= 1'b0;
		end else begin
			MEM_CLK_O <= ~MEM_CLK_O;
			MEM_CLOCK_ENABLE_OUT_O <= (pd_state_q == PD_AWAKE);
			POWER_DOWN_O <= (pd_state_q == PD_ASLEEP);
		end
	end

	// ****************************************
	// event counters
	// ****************************************
	logic half_en_q;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			half_en_q <= 1'b0;
		end else begin
			half_en_q <= ~half_en_q;
		end
	end

	logic [1:0] hit;

	for (genvar n = 0; n < 2; n++) begin : g_cnt
		logic [CNT_HALF-1:0] cfg;
		logic [CNT_HALF-1:0] sel;
		logic [CODE_W-1:0] code;
		logic id_ok;
		logic reg_ok;
		logic raw;
		logic id_applies;
		logic reg_applies;

		assign cfg = event_counter_setup_q[n*CNT_HALF +: CNT_HALF];
		assign sel = filter_value_select_q[n*CNT_HALF +: CNT_HALF];
		assign code = cfg[CODE_LSB +: CODE_W];
		assign id_applies = (code <= EV_WRITE) || (code == EV_ELEVATE) || (code == EV_MERGE_WR);
		assign reg_applies = (code == EV_READ) || (code == EV_WRITE) || (code == EV_ELEVATE);
		assign id_ok = !(cfg[INITIATOR_ON_BIT] && id_applies) ||
			(CMD_EV_I.master_id == sel[SEL_MASTER_LSB +: MASTER_W]);
		assign reg_ok = !(cfg[REGION_ON_BIT] && reg_applies) ||
			(CMD_EV_I.region == sel[SEL_REGION_LSB +: REGION_W]);

		always_comb begin
			raw = 1'b0;
			case (code)
				EV_ACCESS: raw = CMD_EV_I.valid;
				EV_ACTIVATE: raw = CMD_EV_I.valid && CMD_EV_I.activate;
				EV_READ: raw = CMD_EV_I.valid && CMD_EV_I.is_read;
				EV_WRITE: raw = CMD_EV_I.valid && CMD_EV_I.is_write;
				EV_CMDQ_FULL: raw = half_en_q && Q_STAT_I.cmd_full;
				EV_WDATQ_FULL: raw = half_en_q && Q_STAT_I.wdat_full;
				EV_RDATQ_FULL: raw = half_en_q && Q_STAT_I.rdat_full;
				EV_WSTATQ_FULL: raw = half_en_q && Q_STAT_I.wstat_full;
				EV_ELEVATE: raw = CMD_EV_I.valid && CMD_EV_I.elevate;
				EV_PENDING: raw = half_en_q && Q_STAT_I.cmd_pending;
				EV_XFER: raw = half_en_q && Q_STAT_I.xfer_busy;
				EV_MERGE_RD: raw = CMD_EV_I.valid && CMD_EV_I.merge_rd;
				EV_MERGE_WR: raw = CMD_EV_I.valid && CMD_EV_I.merge_wr;
				default: raw = 1'b0;
			endcase
		end

		assign hit[n] = raw && id_ok && reg_ok;

		always_ff @(posedge CLK_I or posedge RST_I) begin
			if (RST_I) begin
				count_q[n] <= RESET_ZERO;
			end else if (hit[n]) begin
				count_q[n] <= count_q[n] + 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_key_capture;
		@(posedge CLK_I) disable iff (RST_I)
		(wr_ctl && REG_WDATA_I[SCR_ENABLE_BIT] && !scr_enable_q) |=> (key_lat_q == $past(key_q));
	endproperty
	a_key_capture: assert property (p_key_capture) else $error("key not captured on enable");

	property p_key_hold;
		@(posedge CLK_I) disable iff (RST_I)
		(scr_enable_q && $past(scr_enable_q)) |-> $stable(key_lat_q);
	endproperty
	a_key_hold: assert property (p_key_hold) else $error("captured key moved while enabled");

	property p_scramble;
		@(posedge CLK_I) disable iff (RST_I)
		scr_enable_q |=> (WR_BEAT_O.data == ($past(WR_BEAT_I.data) ^ $past(key_wide) ^ page_mask($past(WR_BEAT_I.addr))));
	endproperty
	a_scramble: assert property (p_scramble) else $error("write data not scrambled");

	property p_plain;
		@(posedge CLK_I) disable iff (RST_I)
		!scr_enable_q |=> (RD_BEAT_O == $past(RD_BEAT_I));
	endproperty
	a_plain: assert property (p_plain) else $error("read data altered while disabled");

	property p_latency;
		@(posedge CLK_I) disable iff (RST_I)
		WR_BEAT_I.valid |=> WR_BEAT_O.valid;
	endproperty
	a_latency: assert property (p_latency) else $error("write beat latency is not one cycle");

	property p_enter_pd;
		@(posedge CLK_I) disable iff (RST_I)
		(pd_state_q == PD_AWAKE && !wake && !busy && idle_cnt_q == idle_to_sleep_cycles_q)
		|=> ##1 !MEM_CLOCK_ENABLE_OUT_O;
	endproperty
	a_enter_pd: assert property (p_enter_pd) else $error("no power-down after idle count");

	property p_clock_runs;
		@(posedge CLK_I) disable iff (RST_I)
		POWER_DOWN_O |=> (MEM_CLK_O != $past(MEM_CLK_O));
	endproperty
	a_clock_runs: assert property (p_clock_runs) else $error("memory clock stopped in power-down");

	property p_wake;
		@(posedge CLK_I) disable iff (RST_I)
		(pd_state_q == PD_ASLEEP && wake) |=> ##1 MEM_CLOCK_ENABLE_OUT_O;
	endproperty
	a_wake: assert property (p_wake) else $error("no exit from power-down");

	property p_reg_in_pd;
		@(posedge CLK_I) disable iff (RST_I)
		(POWER_DOWN_O && REG_RD_I && REG_ADDR_I == OFF_SCRAMBLE_KEY) |=> (REG_RDATA_O[KEY_W-1:0] == key_q);
	endproperty
	a_reg_in_pd: assert property (p_reg_in_pd) else $error("register read failed in power-down");

	property p_count_step;
		@(posedge CLK_I) disable iff (RST_I)
		hit[0] |=> (count_q[0] == $past(count_q[0]) + 32'h0000_0001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter one did not step");

	property p_reserved;
		@(posedge CLK_I) disable iff (RST_I)
		(event_counter_setup_q[CODE_LSB +: CODE_W] > EV_MERGE_WR) |=> $stable(count_q[0]);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code counted");

	property p_half_rate;
		@(posedge CLK_I) disable iff (RST_I)
		(event_counter_setup_q[CODE_LSB +: CODE_W] == EV_PENDING && !half_en_q) |=> $stable(count_q[0]);
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("cycle event counted off half-rate");

	c_pd_cycle: cover property (@(posedge CLK_I) disable iff (RST_I) POWER_DOWN_O ##[1:50] !POWER_DOWN_O);
	c_scr_on: cover property (@(posedge CLK_I) disable iff (RST_I) scr_enable_q && WR_BEAT_O.valid);
	c_both_hit: cover property (@(posedge CLK_I) disable iff (RST_I) hit[0] && hit[1]);

endmodule // sdram_aux
`default_nettype wire

//--- sdram_model.sv
// far-side sdram model: keeps what the controller writes and returns it on request
`default_nettype none
module sdram_model
	import sdram_aux_pkg::*;
(
	// clock
	input wire logic clk_i,
	// beats from and to the controller
	input wire mem_beat_s wr_beat_i,
	input wire logic rd_req_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output mem_beat_s rd_beat_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [DATA_W-1:0] mem_q [logic [ADDR_W-1:0]];

	initial rd_beat_o = '0;

	// the array only ever holds what left the scrambler, so reads return scrambled words
	always @(posedge clk_i) begin
		if (wr_beat_i.valid)
			mem_q[wr_beat_i.addr] = wr_beat_i.data;
		if (rd_req_i)
			rd_beat_o <= '{1'b1, rd_addr_i, mem_q[rd_addr_i]};
		else
			// released bus: show the inverse so a stale word is never taken for a fresh one
			rd_beat_o <= '{1'b0, ~rd_beat_o.addr, ~rd_beat_o.data};
	end
endmodule // sdram_model
`default_nettype wire

//--- sdram_aux_test.sv
// self-checking bench of the sdram auxiliary block
`default_nettype none
module sdram_aux_test import sdram_aux_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int IDLE = 5;
	localparam int LIMIT = 20000;
	logic clk, rst, reg_wr, reg_rd, mem_req, urgent, rq_v, prev;
	logic [REG_AW-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v1, v2;
	logic [ADDR_W-1:0] rq_a;
	mem_beat_s wr_in, wr_out, rd_in, rd_out;
	cmd_ev_s cmd;
	q_stat_s qs;
	logic mem_clk, cke, pd;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	int n;
	logic [REG_AW-1:0] regs [9] = '{OFF_POWER_MGMT_CONTROL, OFF_EVENT_COUNTER_ONE, OFF_EVENT_COUNTER_TWO,
		OFF_EVENT_COUNTER_SETUP, OFF_FILTER_VALUE_SELECT, OFF_SCRAMBLE_CONTROL, OFF_SCRAMBLE_KEY, OFF_AUX_STATUS, 8'h04};
	logic [3:0] ccodes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
	logic [3:0] qcodes [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha};
	logic [31:0] addrs [3] = '{32'h0000_0400, 32'h0000_0800, 32'h03ff_fc08};

	sdram_aux dut (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
		.REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .WR_BEAT_I(wr_in), .WR_BEAT_O(wr_out), .RD_BEAT_I(rd_in),
		.RD_BEAT_O(rd_out), .CMD_EV_I(cmd), .Q_STAT_I(qs), .MEM_REQ_I(mem_req), .REFRESH_URGENT_I(urgent),
		.MEM_CLK_O(mem_clk), .MEM_CLOCK_ENABLE_OUT_O(cke), .POWER_DOWN_O(pd));
	sdram_model mem (.clk_i(clk), .wr_beat_i(wr_out), .rd_req_i(rq_v), .rd_addr_i(rq_a), .rd_beat_o(rd_in));

	// ********
	// helpers
	// ********
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("compares %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask

	task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic rdchk(input logic [REG_AW-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		check(d, e);
	endtask

	// qualifier order: activate, read, write, elevate, merge read, merge write
	task automatic pulse(input logic [5:0] q, input logic [7:0] m, input logic [1:0] r);
		@(posedge clk);
		cmd <= {1'b1, q, m, r};
		@(posedge clk);
		cmd <= '0;
	endtask

	function automatic logic [63:0] scr(input logic [15:0] k, input logic [31:0] a, input logic [63:0] d);
		logic [15:0] p;
		p = {a[24:10], a[25]};
		return d ^ {k, ~k, k[10:0], k[15:11], k ^ KEY_SALT} ^ {4{p}};
	endfunction

	task automatic beat(input logic [31:0] a, input logic [63:0] d, input logic [63:0] e);
		@(posedge clk);
		wr_in <= '{1'b1, a, d};
		@(posedge clk);
		wr_in.valid <= 1'b0;
		#1;
		check({wr_out.valid, wr_out.addr}, {1'b1, a});
		check(wr_out.data, e);
	endtask

	task automatic back(input logic [31:0] a, input logic [63:0] e);
		@(posedge clk);
		rq_v <= 1'b1;
		rq_a <= a;
		@(posedge clk);
		rq_v <= 1'b0;
		@(posedge clk);
		#1;
		check(rd_out.valid, 1'b1);
		check(rd_out.data, e);
	endtask

	// waits for power-down (1) or for clock enable back high (0)
	task automatic wait_st(input logic want_pd);
		n = 0;
		while ((want_pd ? pd : cke) !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			$display("wrong value at %0t: run did not finish", $time);
			complete_run();
		end
	end

	// ********
	// tests
	// ********
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, mem_req, urgent, rq_v} = '0;
		reg_addr = '0;
		reg_wdata = '0;
		rq_a = '0;
		wr_in = '0;
		cmd = '0;
		qs = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;

		foreach (regs[i])
			rdchk(regs[i], 32'h0);
		wr(OFF_FILTER_VALUE_SELECT, 32'h1201_5a02);
		rdchk(OFF_FILTER_VALUE_SELECT, 32'h1201_5a02);
		wr(OFF_EVENT_COUNTER_ONE, 32'hffff_ffff);
		rdchk(OFF_EVENT_COUNTER_ONE, 32'h0);
		wr(8'h04, 32'hffff_ffff);
		rdchk(8'h04, 32'h0);
		end_test("registers");

		// plain pass-through first: same one-cycle latency as when scrambling
		beat(addrs[0], 64'h0123_4567_89ab_cdef, 64'h0123_4567_89ab_cdef);
		wr(OFF_SCRAMBLE_KEY, 32'h0000_1234);
		rdchk(OFF_SCRAMBLE_KEY, 32'h0000_1234);
		wr(OFF_SCRAMBLE_CONTROL, 32'h1);
		// key changed after enabling on purpose: the captured copy must stay in use
		wr(OFF_SCRAMBLE_KEY, 32'h0000_beef);
		rdchk(OFF_AUX_STATUS, 32'h2);
		for (int i = 0; i < 3; i++)
			beat(addrs[i], 64'h0123_4567_89ab_cdef ^ 64'(i), scr(16'h1234, addrs[i], 64'h0123_4567_89ab_cdef ^ 64'(i)));
		for (int i = 0; i < 3; i++)
			back(addrs[i], 64'h0123_4567_89ab_cdef ^ 64'(i));
		end_test("scrambler");

		@(posedge clk);
		mem_req <= 1'b1;
		wr(OFF_POWER_MGMT_CONTROL, {21'h0, 3'h4, 8'(IDLE)});
		repeat (3 * IDLE) @(posedge clk);
		#1;
		check(pd, 1'b0);
		@(posedge clk);
		mem_req <= 1'b0;
		wait_st(1'b1);
		check(n >= IDLE + 2 && n <= IDLE + 3, 1'b1);
		check(cke, 1'b0);
		n = 0;
		repeat (6) begin
			prev = mem_clk;
			@(posedge clk);
			#1;
			n += (mem_clk !== prev) + 2 * (cke !== 1'b0);
		end
		check(n, 6);
		rdchk(OFF_AUX_STATUS, 32'h3);
		rdchk(OFF_POWER_MGMT_CONTROL, {21'h0, 3'h4, 8'(IDLE)});
		rdchk(OFF_SCRAMBLE_KEY, 32'h0000_beef);
		for (int k = 0; k < 3; k++) begin
			if (k > 0) begin
				wr(OFF_POWER_MGMT_CONTROL, {21'h0, 3'h4, 8'(IDLE)});
				wait_st(1'b1);
			end
			if (k == 0)
				wr(OFF_POWER_MGMT_CONTROL, {24'h0, 8'(IDLE)});
			@(posedge clk);
			mem_req <= (k == 1);
			urgent <= (k == 2);
			wait_st(1'b0);
			check({n <= 4, pd}, 2'b10);
			@(posedge clk);
			mem_req <= 1'b0;
			urgent <= 1'b0;
		end
		wr(OFF_POWER_MGMT_CONTROL, 32'h0);
		end_test("power-down");

		foreach (ccodes[i]) begin
			wr(OFF_EVENT_COUNTER_SETUP, {28'h0, ccodes[i]});
			rd(OFF_EVENT_COUNTER_ONE, v1);
			rd(OFF_EVENT_COUNTER_TWO, v2);
			for (int j = 0; j < 6; j++)
				pulse(6'h1 << j, 8'h00, 2'h0);
			repeat (2) @(posedge clk);
			rdchk(OFF_EVENT_COUNTER_ONE, v1 + ((ccodes[i] == EV_ACCESS) ? 6 : (ccodes[i] > EV_MERGE_WR) ? 0 : 1));
			rdchk(OFF_EVENT_COUNTER_TWO, v2 + 6);
		end
		foreach (qcodes[i]) begin
			wr(OFF_EVENT_COUNTER_SETUP, {12'h0, (i == 0) ? EV_WDATQ_FULL : EV_CMDQ_FULL, 12'h0, qcodes[i]});
			rd(OFF_EVENT_COUNTER_ONE, v1);
			rd(OFF_EVENT_COUNTER_TWO, v2);
			@(posedge clk);
			qs <= 6'h20 >> i;
			// eight sampled cycles hold exactly four half-rate slots, whatever the phase
			repeat (8) @(posedge clk);
			qs <= '0;
			repeat (2) @(posedge clk);
			rdchk(OFF_EVENT_COUNTER_ONE, v1 + 4);
			rdchk(OFF_EVENT_COUNTER_TWO, v2);
		end
		wr(OFF_FILTER_VALUE_SELECT, 32'h0000_5a02);
		wr(OFF_EVENT_COUNTER_SETUP, 32'h4001_c002);
		rdchk(OFF_EVENT_COUNTER_SETUP, 32'h4001_c002);
		rd(OFF_EVENT_COUNTER_ONE, v1);
		rd(OFF_EVENT_COUNTER_TWO, v2);
		pulse(6'h10, 8'h5a, 2'h2);
		pulse(6'h10, 8'h5a, 2'h1);
		pulse(6'h10, 8'h33, 2'h2);
		pulse(6'h20, 8'h33, 2'h1);
		repeat (2) @(posedge clk);
		rdchk(OFF_EVENT_COUNTER_ONE, v1 + 1);
		rdchk(OFF_EVENT_COUNTER_TWO, v2 + 1);
		end_test("counters");
		complete_run();
	end
endmodule // sdram_aux_test
`default_nettype wire
